// *** src/mbad_defines.vh ***
/*
 Address map constants for the slave address decoder.
 Assumes inclusion by the decoder only; definitions only.
*/
`ifndef MBAD_DEFINES_VH
`define MBAD_DEFINES_VH

// Function codes
`define MBAD_FC_RD_COIL 8'h01
`define MBAD_FC_RD_DISC 8'h02
`define MBAD_FC_RD_HOLD 8'h03
`define MBAD_FC_RD_INP 8'h04
`define MBAD_FC_WR_COIL 8'h05
`define MBAD_FC_WR_REG 8'h06
`define MBAD_FC_WR_COILS 8'h0F
`define MBAD_FC_WR_REGS 8'h10
`define MBAD_FC_MASK_WR 8'h16
`define MBAD_FC_RW_REGS 8'h17

// Bit area bases
`define MBAD_BIT_OUT_BASE 16'h0000
`define MBAD_BIT_IN_BASE 16'h1800
`define MBAD_BIT_FLAG_BASE 16'h3000

// Register area bases
`define MBAD_REG_IN_BASE 16'h0000
`define MBAD_REG_OUT_BASE 16'h03E8
`define MBAD_REG_GAP_BASE 16'h07D0
`define MBAD_REG_CFG_BASE 16'h1000
`define MBAD_REG_FLAG_BASE 16'h3000

// Flag size in words: default 24 kB, maximum 104 kB
`define MBAD_FLAG_DEF_WORDS 16'h3000
`define MBAD_FLAG_MAX_WORDS 16'hD000

// Exception codes
`define MBAD_EXC_NONE 8'h00
`define MBAD_EXC_FUNC 8'h01
`define MBAD_EXC_ADDR 8'h02

// Target areas
`define MBAD_TGT_NONE 3'h0
`define MBAD_TGT_IPI 3'h1
`define MBAD_TGT_OPI 3'h2
`define MBAD_TGT_FLAG 3'h3
`define MBAD_TGT_CFG 3'h4

`endif

// *** src/mbad_decoder.v ***
/*
 Modbus slave address decoder: maps one request onto a memory area,
 word index and bit index, or yields an exception code.
 Also holds the small splitter that turns a bit address into word and bit.
 Assumes the frame layer presents one request per strobe and that
 memories outside act on the registered target outputs.
 The flag size input is expected to stay steady while requests arrive.
*/
// Operation
// R1: FC1/2 low bits read output image words (code reads the input image, MBAD_TGT_IPI)
// R2: FC1/2 mid bits read input image words (code reads the output image, MBAD_TGT_OPI)
// R3: Bits from 12288 reach flag memory
// R4: FC5/15 low bits write output image (code writes the input image, MBAD_TGT_IPI)
// R5: FC5/15 mid bits refused, exception 2
// R6: Config registers at 4096..12287, listed codes
// R7: Flag registers via FC3,4,6,16,22,23
// R8: Flag size configurable, default 24 kB
// R9: No locking between Modbus and program
// R10: Register reads: 0..999 input, 1000..1999 output
// R11: Register reads 2000..4095 refused, exception 2
// R12: Offset div 16 word, remainder bit
`timescale 1ns/10ps
`include "mbad_defines.vh"

module mbad_decoder (
	input wire clk_sys_i,
	input wire sys_rst_i,
	input wire req_valid_i,
	input wire [7:0] req_func_i,
	input wire [15:0] req_addr_i,
	input wire [15:0] flag_words_i,
	output reg rsp_valid_o,
	output reg [2:0] rsp_target_o,
	output reg [15:0] rsp_word_o,
	output reg [3:0] rsp_bit_o,
	output reg rsp_write_o,
	output reg [7:0] rsp_exc_o
);

	reg [2:0] tgt_d;
	reg [15:0] word_d;
	reg [3:0] bit_d;
	reg wr_d;
	reg [7:0] exc_d;
	reg [15:0] off;
	reg [15:0] lim;
	reg is_bit_rd;
	reg is_bit_wr;
	reg is_reg_rd;
	reg is_reg_wr;
	wire [15:0] out_bit_word;
	wire [3:0] out_bit_idx;
	wire [15:0] in_bit_word;
	wire [3:0] in_bit_idx;
	wire [15:0] flag_bit_word;
	wire [3:0] flag_bit_idx;

	// Word and bit split of each bit region; one subtractor per base
	// keeps the decode chain short, at the cost of three adders. R12
	mbad_bit_split #(
		.BASE(`MBAD_BIT_OUT_BASE)
	) u_split_out (
		.addr_i(req_addr_i),
		.word_o(out_bit_word),
		.bit_o(out_bit_idx)
	);

	mbad_bit_split #(
		.BASE(`MBAD_BIT_IN_BASE)
	) u_split_in (
		.addr_i(req_addr_i),
		.word_o(in_bit_word),
		.bit_o(in_bit_idx)
	);

	mbad_bit_split #(
		.BASE(`MBAD_BIT_FLAG_BASE)
	) u_split_flag (
		.addr_i(req_addr_i),
		.word_o(flag_bit_word),
		.bit_o(flag_bit_idx)
	);

	// Classify the function code
	always @* begin
		is_bit_rd = (req_func_i == `MBAD_FC_RD_COIL) || (req_func_i == `MBAD_FC_RD_DISC);
		is_bit_wr = (req_func_i == `MBAD_FC_WR_COIL) || (req_func_i == `MBAD_FC_WR_COILS);
		is_reg_rd = (req_func_i == `MBAD_FC_RD_HOLD) || (req_func_i == `MBAD_FC_RD_INP)
			|| (req_func_i == `MBAD_FC_RW_REGS);
		is_reg_wr = (req_func_i == `MBAD_FC_WR_REG) || (req_func_i == `MBAD_FC_WR_REGS)
			|| (req_func_i == `MBAD_FC_MASK_WR) || (req_func_i == `MBAD_FC_RW_REGS);
	end

	// Clamp configured flag size; zero falls back to default
	always @* begin
		if (flag_words_i == 16'h0000) begin
			lim = `MBAD_FLAG_DEF_WORDS; // R8
		end else if (flag_words_i > `MBAD_FLAG_MAX_WORDS) begin
			lim = `MBAD_FLAG_MAX_WORDS; // R8
		end else begin
			lim = flag_words_i;
		end
	end

	// Area decode; address compare chain, highest area first
	always @* begin
		tgt_d = `MBAD_TGT_NONE;
		word_d = 16'h0000;
		bit_d = 4'h0;
		wr_d = 1'b0;
		exc_d = `MBAD_EXC_NONE;
		off = 16'h0000;
		if (is_bit_rd || is_bit_wr) begin
			wr_d = is_bit_wr;
			if (req_addr_i >= `MBAD_BIT_FLAG_BASE) begin
				word_d = flag_bit_word; // R12
				bit_d = flag_bit_idx; // R12
				// Bit view lies in the first words of flag memory
				if (word_d < lim) begin
					tgt_d = `MBAD_TGT_FLAG; // R3
				end else begin
					exc_d = `MBAD_EXC_ADDR; // R8
				end
			end else if (req_addr_i >= `MBAD_BIT_IN_BASE) begin
				word_d = in_bit_word; // R12
				bit_d = in_bit_idx;
				// Bit writes here would clobber program outputs
				if (is_bit_wr) begin
					exc_d = `MBAD_EXC_ADDR; // R5
					wr_d = 1'b0; // R5
				end else begin
					tgt_d = `MBAD_TGT_OPI; // R2
				end
			end else begin
				word_d = out_bit_word; // R12
				bit_d = out_bit_idx;
				tgt_d = `MBAD_TGT_IPI; // R1 R4
			end
		end else if (is_reg_rd || is_reg_wr) begin
			wr_d = is_reg_wr;
			if (req_addr_i >= `MBAD_REG_FLAG_BASE) begin
				off = req_addr_i - `MBAD_REG_FLAG_BASE;
				word_d = off;
				if (off < lim) begin
					tgt_d = `MBAD_TGT_FLAG; // R7
				end else begin
					exc_d = `MBAD_EXC_ADDR; // R8
				end
			end else if (req_addr_i >= `MBAD_REG_CFG_BASE) begin
				// Validity of single config registers is left to the register file
				word_d = req_addr_i - `MBAD_REG_CFG_BASE;
				// Mask write is not offered on config registers
				if (req_func_i == `MBAD_FC_MASK_WR) begin
					exc_d = `MBAD_EXC_FUNC;
				end else begin
					tgt_d = `MBAD_TGT_CFG; // R6
				end
			end else if (req_addr_i >= `MBAD_REG_GAP_BASE) begin
				exc_d = `MBAD_EXC_ADDR; // R11
			end else if (req_addr_i >= `MBAD_REG_OUT_BASE) begin
				// Writes here would overwrite program outputs, so they are refused
				word_d = req_addr_i - `MBAD_REG_OUT_BASE;
				if (is_reg_rd) begin
					tgt_d = `MBAD_TGT_OPI; // R10
					wr_d = 1'b0; // Only read half of combined service
				end else begin
					exc_d = `MBAD_EXC_ADDR;
				end
			end else begin
				word_d = req_addr_i - `MBAD_REG_IN_BASE;
				tgt_d = `MBAD_TGT_IPI; // R10
			end
		end else begin
			exc_d = `MBAD_EXC_FUNC;
		end
		if (exc_d != `MBAD_EXC_NONE) begin
			tgt_d = `MBAD_TGT_NONE;
			wr_d = 1'b0;
		end
	end

	// Register the answer; one cycle after the request.
	// No locking against program access to flags: the program
	// side must keep clear of words that Modbus is using.
	always @(posedge clk_sys_i) begin
		if (sys_rst_i) begin
			rsp_valid_o <= 1'b0;
			rsp_target_o <= `MBAD_TGT_NONE;
			rsp_word_o <= 16'h0000;
			rsp_bit_o <= 4'h0;
			rsp_write_o <= 1'b0;
			rsp_exc_o <= `MBAD_EXC_NONE;
		end else begin
			rsp_valid_o <= req_valid_i;
			if (req_valid_i) begin
				rsp_target_o <= tgt_d; // R9
				rsp_word_o <= word_d;
				rsp_bit_o <= bit_d;
				rsp_write_o <= wr_d;
				rsp_exc_o <= exc_d;
			end
		end
	end

endmodule // mbad_decoder

// Offset from one region base, split into word and bit.
// Wraps below the base; callers only use it above their base.
module mbad_bit_split #(
	parameter [15:0] BASE = 16'h0000
) (
	input wire [15:0] addr_i,
	output wire [15:0] word_o,
	output wire [3:0] bit_o
);

	wire [15:0] off;

	// Sixteen bits per word, least significant bit first
	assign off = addr_i - BASE;
	assign word_o = {4'h0, off[15:4]}; // R12
	assign bit_o = off[3:0]; // R12

endmodule // mbad_bit_split

// *** sim/mbad_master.sv ***
/* Master model: one request per call.
 Assumes the decoder shares its clock. */
`timescale 1ns/10ps
module mbad_master (
	input wire clk_sys_i,
	output logic req_valid_i,
	output logic [7:0] req_func_i,
	output logic [15:0] req_addr_i
);
	initial {req_valid_i, req_func_i, req_addr_i} = 25'h0000000;
	// Idle lines inverted so stale values never pass
	task send(input [7:0] f, input [15:0] a);
		@(posedge clk_sys_i) #1 {req_valid_i, req_func_i, req_addr_i} = {1'b1, f, a};
		@(posedge clk_sys_i) #1 {req_valid_i, req_func_i, req_addr_i} = {1'b0, ~f, ~a};
	endtask
endmodule // mbad_master

// *** sim/mbad_decoder_monitor.sv ***
/* Port checker of the decoder.
 Assumes one clock and sync reset. */
`timescale 1ns/10ps
module mbad_monitor (
	input wire clk_sys_i,
	input wire sys_rst_i,
	input wire req_valid_i,
	input wire [7:0] req_func_i,
	input wire [15:0] req_addr_i,
	input wire [15:0] flag_words_i,
	input wire rsp_valid_o,
	input wire [2:0] rsp_target_o,
	input wire [15:0] rsp_word_o,
	input wire [3:0] rsp_bit_o,
	input wire rsp_write_o,
	input wire [7:0] rsp_exc_o
);
	// Request classes
	wire [15:0] a = req_addr_i;
	wire rb = req_valid_i && (req_func_i == 8'h01 || req_func_i == 8'h02);
	wire wb = req_valid_i && (req_func_i == 8'h05 || req_func_i == 8'h0F);
	wire rr = req_valid_i && (req_func_i == 8'h03 || req_func_i == 8'h04);
	wire mid = a >= 16'h1800 && a < 16'h3000;
	wire [2:0] t = rsp_target_o;
	default clocking @(posedge clk_sys_i); endclocking
	default disable iff (sys_rst_i);
	a_low_bits: assert property (rb && a < 16'h1800 |=> t == 3'h1 && rsp_word_o == $past(a) >> 4
		&& rsp_bit_o == $past(a[3:0])) else $error("low bits");
	a_mid_bits: assert property (rb && mid |=> t == 3'h2 && rsp_word_o == ($past(a) - 16'h1800) >> 4)
		else $error("mid bits");
	a_flag_bits: assert property ((rb || wb) && a >= 16'h3000 && flag_words_i == 16'h0000 |=> t == 3'h3)
		else $error("flag bits");
	a_low_write: assert property (wb && a < 16'h1800 |=> rsp_write_o && t == 3'h1) else $error("bit write");
	a_mid_refused: assert property (wb && mid |=> rsp_exc_o == 8'h02 && !rsp_write_o && t == 3'h0)
		else $error("refusal");
	a_cfg_regs: assert property (rr && a >= 16'h1000 && a < 16'h3000 |=> t == 3'h4) else $error("cfg");
	a_reg_images: assert property (rr && a < 16'h07D0 |=> t == ($past(a) < 16'h03E8 ? 3'h1 : 3'h2))
		else $error("images");
	a_reg_gap: assert property (rr && a >= 16'h07D0 && a < 16'h1000 |=> rsp_exc_o == 8'h02) else $error("gap");
	a_flag_regs: assert property (rr && a >= 16'h3000 && flag_words_i == 16'h0000
		|=> ($past(a) < 16'h6000 ? t == 3'h3 : rsp_exc_o == 8'h02)) else $error("flag regs");
	a_fault_clean: assert property (req_valid_i |=> rsp_exc_o == 8'h00 || (t == 3'h0 && !rsp_write_o))
		else $error("fault clean");
endmodule // mbad_monitor
bind mbad_decoder mbad_monitor u_mon (
	.clk_sys_i(clk_sys_i),
	.sys_rst_i(sys_rst_i),
	.req_valid_i(req_valid_i),
	.req_func_i(req_func_i),
	.req_addr_i(req_addr_i),
	.flag_words_i(flag_words_i),
	.rsp_valid_o(rsp_valid_o),
	.rsp_target_o(rsp_target_o),
	.rsp_word_o(rsp_word_o),
	.rsp_bit_o(rsp_bit_o),
	.rsp_write_o(rsp_write_o),
	.rsp_exc_o(rsp_exc_o)
);

// *** sim/modbus_slave_address_decoder_tb.sv ***
/* Self-checking bench of the decoder.
 Assumes the master model and bound checker. */
`timescale 1ns/10ps
module modbus_slave_address_decoder_tb;
	logic clk_sys_i = 1'b0, sys_rst_i = 1'b1, req_valid_i, rsp_valid_o, rsp_write_o;
	logic [7:0] req_func_i, rsp_exc_o;
	logic [15:0] req_addr_i, rsp_word_o, flag_words_i = 16'h0000;
	logic [2:0] rsp_target_o;
	logic [3:0] rsp_bit_o;
	int mismatches = 0, num_checks = 0;
	mbad_decoder uut (
		.clk_sys_i(clk_sys_i),
		.sys_rst_i(sys_rst_i),
		.req_valid_i(req_valid_i),
		.req_func_i(req_func_i),
		.req_addr_i(req_addr_i),
		.flag_words_i(flag_words_i),
		.rsp_valid_o(rsp_valid_o),
		.rsp_target_o(rsp_target_o),
		.rsp_word_o(rsp_word_o),
		.rsp_bit_o(rsp_bit_o),
		.rsp_write_o(rsp_write_o),
		.rsp_exc_o(rsp_exc_o)
	);
	mbad_master m (
		.clk_sys_i(clk_sys_i),
		.req_valid_i(req_valid_i),
		.req_func_i(req_func_i),
		.req_addr_i(req_addr_i)
	);
	initial forever #25 clk_sys_i = ~clk_sys_i;
	task chk(input logic [23:0] s, e);
		num_checks++;
		if (s !== e) begin
			mismatches++;
			$display("unexpected at %0t: got %h want %h", $time, s, e);
		end
	endtask
	// Send, then judge answer in its one valid cycle; wt is write and target
	task req(input [7:0] f, input [15:0] a, input [3:0] wt, input [7:0] e, input [15:0] w, input [3:0] b);
		m.send(f, a);
		chk({11'h0, rsp_valid_o, rsp_write_o, rsp_target_o, rsp_exc_o}, {11'h0, 1'b1, wt, e});
		if (e == 8'h00)
			chk({rsp_word_o, 4'h0, rsp_bit_o}, {w, 4'h0, b});
		// Strobe drops after one cycle while the rest holds
		@(posedge clk_sys_i);
		#1 chk({11'h0, rsp_valid_o, rsp_write_o, rsp_target_o, rsp_exc_o}, {11'h0, 1'b0, wt, e});
	endtask
	task t_bits;
		req(8'h01, 16'h17FF, 4'h1, 8'h00, 16'h017F, 4'hF);
		req(8'h02, 16'h1800, 4'h2, 8'h00, 16'h0000, 4'h0);
		req(8'h0F, 16'h1805, 4'h0, 8'h02, 16'h0000, 4'h0);
		req(8'h05, 16'h17F3, 4'h9, 8'h00, 16'h017F, 4'h3);
		req(8'h0F, 16'hFFFF, 4'hB, 8'h00, 16'h0CFF, 4'hF);
		req(8'h01, 16'h3000, 4'h3, 8'h00, 16'h0000, 4'h0);
	endtask
	task t_regs;
		req(8'h04, 16'h03E7, 4'h1, 8'h00, 16'h03E7, 4'h0);
		req(8'h03, 16'h07CF, 4'h2, 8'h00, 16'h03E7, 4'h0);
		req(8'h03, 16'h07D0, 4'h0, 8'h02, 16'h0000, 4'h0);
		req(8'h06, 16'h2FFF, 4'hC, 8'h00, 16'h1FFF, 4'h0);
		req(8'h04, 16'h1000, 4'h4, 8'h00, 16'h0000, 4'h0);
		req(8'h16, 16'h1000, 4'h0, 8'h01, 16'h0000, 4'h0);
		req(8'h06, 16'h03E8, 4'h0, 8'h02, 16'h0000, 4'h0);
		req(8'h17, 16'h03E8, 4'h2, 8'h00, 16'h0000, 4'h0);
		req(8'h06, 16'h0000, 4'h9, 8'h00, 16'h0000, 4'h0);
		req(8'h2B, 16'h0000, 4'h0, 8'h01, 16'h0000, 4'h0);
	endtask
	// Default size, clamp, then a tiny area
	task t_flag;
		req(8'h10, 16'h5FFF, 4'hB, 8'h00, 16'h2FFF, 4'h0);
		req(8'h16, 16'h6000, 4'h0, 8'h02, 16'h0000, 4'h0);
		req(8'h04, 16'h6000, 4'h0, 8'h02, 16'h0000, 4'h0);
		req(8'h03, 16'h3000, 4'h3, 8'h00, 16'h0000, 4'h0);
		flag_words_i = 16'hFFFF;
		req(8'h03, 16'hFFFF, 4'h3, 8'h00, 16'hCFFF, 4'h0);
		flag_words_i = 16'h0010;
		req(8'h17, 16'h3010, 4'h0, 8'h02, 16'h0000, 4'h0);
		req(8'h01, 16'h30FF, 4'h3, 8'h00, 16'h000F, 4'hF);
		req(8'h05, 16'h3100, 4'h0, 8'h02, 16'h0000, 4'h0);
	endtask
	// Mid-run reset clears every output, then service resumes
	task t_reset;
		req(8'h02, 16'h1FFF, 4'h2, 8'h00, 16'h007F, 4'hF);
		sys_rst_i = 1'b1;
		@(posedge clk_sys_i);
		#1 sys_rst_i = 1'b0;
		chk({11'h0, rsp_valid_o, rsp_write_o, rsp_target_o, rsp_exc_o}, 24'h000000);
		chk({rsp_word_o, 4'h0, rsp_bit_o}, 24'h000000);
		req(8'h05, 16'h0011, 4'h9, 8'h00, 16'h0001, 4'h1);
	endtask
	task end_of_test;
		if (mismatches == 0 && num_checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	// Tests need about 4 us
	initial begin
		#20us;
		mismatches++;
		end_of_test;
	end
	initial begin
		repeat (5) @(posedge clk_sys_i);
		#1 sys_rst_i = 1'b0;
		t_bits;
		t_regs;
		t_flag;
		t_reset;
		end_of_test;
	end
endmodule // modbus_slave_address_decoder_tb
